// ===== supervisor_pkg.sv
package supervisor_pkg;
	// Clock rate of the internal oscillator
	localparam int unsigned CLK_HZ = 20_000_000;
	// Manual input must stay low longer than this (ns)
	localparam int unsigned MAN_GLITCH_NS = 100;
	// Manual input to reset assertion delay (ns)
	localparam int unsigned MAN_DELAY_NS = 2_000;
	// Supply low glitch rejection (ns)
	localparam int unsigned SUPPLY_GLITCH_NS = 100;
	// Hold timeout, typical (ms)
	localparam int unsigned HOLD_TIMEOUT_MS = 190;
	// Least time rounds up; a count of at least one cycle
	localparam int unsigned MAN_GLITCH_CYC =
		(MAN_GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;
	localparam int unsigned MAN_DELAY_CYC =
		(MAN_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SUPPLY_GLITCH_CYC =
		(SUPPLY_GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000 + 1;
	localparam int unsigned HOLD_TIMEOUT_CYC =
		HOLD_TIMEOUT_MS * (CLK_HZ / 1000);
	// Filter counter width
	localparam int unsigned FILT_W = 8;
	// Hold counter width
	localparam int unsigned HOLD_W = 23;
	// Power-up value of the reset request
	localparam logic RESET_ASSERTED_INIT = 1'h1;
	// Supervisor states
	typedef enum logic [1:0] {
		ST_HOLD = 2'h0,
		ST_RUN = 2'h1
	} sup_state_t;
endpackage

// ===== filter_if.sv
`timescale 1ns/1ns
interface filter_if;
	logic raw;
	logic qualified;
	modport filt (
		input raw,
		output qualified
	);
	modport user (
		output raw,
		input qualified
	);
endinterface

// ===== level_filter.sv
`timescale 1ns/1ns
module level_filter #(
	parameter int unsigned ASSERT_CYC = 3,
	parameter int unsigned W = 8
) (
	input wire logic clock_i,
	input wire logic rst_i,
	filter_if.filt f
);
	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic out_q;
	logic out_d;

	// Count consecutive active cycles; release at once
	always_comb begin
		cnt_d = cnt_q;
		out_d = out_q;
		if (!f.raw) begin
			cnt_d = '0;
			out_d = 1'h0;
		end else if (cnt_q >= W'(ASSERT_CYC - 1)) begin
			out_d = 1'h1;
		end else begin
			cnt_d = cnt_q + W'(1);
		end
	end

	// Register filter state
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_q <= '0;
			out_q <= 1'h0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign f.qualified = out_q;
endmodule // level_filter

// ===== supply_reset_supervisor.sv
`timescale 1ns/1ns
module supply_reset_supervisor #(
	parameter bit ACTIVE_HIGH = 1'h0,
	parameter int unsigned HOLD_CYC = supervisor_pkg::HOLD_TIMEOUT_CYC,
	parameter int unsigned MAN_GLITCH_CYC = supervisor_pkg::MAN_GLITCH_CYC,
	parameter int unsigned MAN_DELAY_CYC = supervisor_pkg::MAN_DELAY_CYC,
	parameter int unsigned SUPPLY_GLITCH_CYC =
		supervisor_pkg::SUPPLY_GLITCH_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic supply_low_i,
	input wire logic manual_reset_n_i,
	output logic reset_o
);
	localparam int unsigned FW = supervisor_pkg::FILT_W;
	localparam int unsigned HW = supervisor_pkg::HOLD_W;

	// Two-stage synchronisers for the asynchronous pins
	logic sup_s1_q;
	logic sup_s1_d;
	logic sup_s2_q;
	logic sup_s2_d;
	logic man_s1_q;
	logic man_s1_d;
	logic man_s2_q;
	logic man_s2_d;

	// Next synchroniser values; only the second stage feeds logic
	always_comb begin
		sup_s1_d = supply_low_i;
		sup_s2_d = sup_s1_q;
		man_s1_d = manual_reset_n_i;
		man_s2_d = man_s1_q;
	end

	// Register synchronisers; init reads supply low and manual idle
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sup_s1_q <= 1'h1;
			sup_s2_q <= 1'h1;
			man_s1_q <= 1'h1;
			man_s2_q <= 1'h1;
		end else begin
			sup_s1_q <= sup_s1_d;
			sup_s2_q <= sup_s2_d;
			man_s1_q <= man_s1_d;
			man_s2_q <= man_s2_d;
		end
	end

	// Supply glitch filter; supply trip level itself is analog
	filter_if sup_if ();
	assign sup_if.raw = sup_s2_q;
	level_filter #(
		.ASSERT_CYC(SUPPLY_GLITCH_CYC),
		.W(FW)
	) u_sup_filt (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.f(sup_if)
	);

	// Manual input glitch filter, low level counts as active
	filter_if man_if ();
	assign man_if.raw = !man_s2_q;
	level_filter #(
		.ASSERT_CYC(MAN_GLITCH_CYC),
		.W(FW)
	) u_man_filt (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.f(man_if)
	);

	// Assertion delay after a qualified manual request
	logic [FW-1:0] mdly_q;
	logic [FW-1:0] mdly_d;
	logic man_req_q;
	logic man_req_d;
	always_comb begin
		mdly_d = mdly_q;
		man_req_d = man_req_q;
		if (!man_if.qualified) begin
			mdly_d = '0;
			man_req_d = 1'h0;
		end else if (mdly_q >= FW'(MAN_DELAY_CYC - 1)) begin
			man_req_d = 1'h1;
		end else begin
			mdly_d = mdly_q + FW'(1);
		end
	end

	// Register manual delay state
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mdly_q <= '0;
			man_req_q <= 1'h0;
		end else begin
			mdly_q <= mdly_d;
			man_req_q <= man_req_d;
		end
	end

	// Any pending condition; supply acts at once, manual after delay
	logic cause;
	assign cause = sup_if.qualified || man_req_q;

	// Hold timer and state
	supervisor_pkg::sup_state_t state_q;
	supervisor_pkg::sup_state_t state_d;
	logic [HW-1:0] hold_q;
	logic [HW-1:0] hold_d;
	logic rst_act_q;
	logic rst_act_d;
	always_comb begin
		state_d = state_q;
		hold_d = hold_q;
		rst_act_d = rst_act_q;
		if (cause) begin
			state_d = supervisor_pkg::ST_HOLD;
			hold_d = '0;
			rst_act_d = 1'h1;
		end else begin
			unique case (state_q)
				supervisor_pkg::ST_HOLD: begin
					rst_act_d = 1'h1;
					if (hold_q >= HW'(HOLD_CYC - 1)) begin
						state_d = supervisor_pkg::ST_RUN;
						rst_act_d = 1'h0;
					end else begin
						hold_d = hold_q + HW'(1);
					end
				end
				supervisor_pkg::ST_RUN: begin
					rst_act_d = 1'h0;
				end
				default: begin
					state_d = supervisor_pkg::ST_HOLD;
					rst_act_d = 1'h1;
				end
			endcase
		end
	end

	// Register hold state; power-up starts in hold with reset active
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_q <= supervisor_pkg::ST_HOLD;
			hold_q <= '0;
			rst_act_q <= supervisor_pkg::RESET_ASSERTED_INIT;
		end else begin
			state_q <= state_d;
			hold_q <= hold_d;
			rst_act_q <= rst_act_d;
		end
	end

	// Polarity selection, timing identical
	logic out_q;
	logic out_d;
	always_comb begin
		out_d = ACTIVE_HIGH ? rst_act_q : !rst_act_q;
	end

	// Register the pin level so the processor never sees a glitch
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			out_q <= ACTIVE_HIGH;
		end else begin
			out_q <= out_d;
		end
	end
	assign reset_o = out_q;
endmodule // supply_reset_supervisor

// ===== supervisor_properties.sv
`timescale 1ns/1ns
module supervisor_properties #(
	parameter bit ACTIVE_HIGH = 1'h0,
	parameter int unsigned HOLD_CYC = 50
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic supply_low_i,
	input wire logic manual_reset_n_i,
	input wire logic reset_o
);
	logic act;
	logic [15:0] low_q, low_d, good_q, good_d;
	// Asserted level and run lengths of manual low and quiet inputs
	assign act = reset_o == ACTIVE_HIGH;
	always_comb begin
		low_d = manual_reset_n_i ? 16'h0 : low_q + {15'h0, low_q < 16'h40};
		good_d = supply_low_i || !manual_reset_n_i ? 16'h0 : good_q + 16'h1;
	end
	always_ff @(posedge clock_i) begin
		low_q <= rst_i ? 16'h0 : low_d;
		good_q <= rst_i ? 16'h0 : good_d;
	end
	default clocking @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	a_low_asserts: assert property (supply_low_i [*8] |=> act)
		else $error("supply low gave no reset");
	a_hold_min: assert property ($fell(supply_low_i) && act &&
		$past(supply_low_i, 2) && $past(supply_low_i, 3) |-> act [*8])
		else $error("reset dropped early");
	a_full_hold: assert property ($fell(act) |-> good_q >= HOLD_CYC)
		else $error("hold shorter than timeout");
	a_release_bound: assert property (good_q == HOLD_CYC + 12 |-> !act)
		else $error("reset not released");
	a_supply_glitch: assert property (!act && !supply_low_i ##1
		supply_low_i [*2] ##1 (!supply_low_i && manual_reset_n_i) [*8]
		|-> !act)
		else $error("supply glitch gave reset");
	a_manual_glitch: assert property (!act && manual_reset_n_i ##1
		(!manual_reset_n_i && !supply_low_i) [*2]
		##1 (manual_reset_n_i && !supply_low_i) [*8] |-> !act)
		else $error("manual glitch gave reset");
	a_manual_delay: assert property (!act && manual_reset_n_i ##1
		(!manual_reset_n_i && !supply_low_i) [*8] |-> !act)
		else $error("manual delay too short");
	a_manual_holds: assert property (low_q >= 16'h34 |-> act)
		else $error("manual low gave no reset");
endmodule // supervisor_properties

// ===== cpu_reset_sink.sv
`timescale 1ns/1ns
module cpu_reset_sink (
	input wire logic clock_i,
	input wire logic reset_n_i,
	output logic [7:0] boots_o
);
	logic held_q = 1'h1;
	logic [7:0] boots_q = 8'h0;
	// Each release of reset is one start; an unknown level counts as held
	always_ff @(posedge clock_i) begin
		held_q <= reset_n_i !== 1'h1;
		boots_q <= boots_q + {7'h0, held_q && reset_n_i === 1'h1};
	end
	assign boots_o = boots_q;
endmodule // cpu_reset_sink

// ===== supply_reset_supervisor_tb.sv
`timescale 1ns/1ns
module supply_reset_supervisor_tb;
	localparam int unsigned HC = 50;
	logic clock_i = 1'h0, rst_i = 1'h1, low = 1'h0, mr_n = 1'h1;
	logic rst_lo, rst_hi, act_s;
	logic [7:0] boots, b;
	int n_mismatch = 0, n_compared = 0, n;
	supply_reset_supervisor #(.HOLD_CYC(HC)) dut (.clock_i(clock_i),
		.rst_i(rst_i), .supply_low_i(low), .manual_reset_n_i(mr_n),
		.reset_o(rst_lo));
	supply_reset_supervisor #(.ACTIVE_HIGH(1'h1), .HOLD_CYC(HC)) dut_hi (
		.clock_i(clock_i), .rst_i(rst_i), .supply_low_i(low),
		.manual_reset_n_i(mr_n), .reset_o(rst_hi));
	cpu_reset_sink cpu (.clock_i(clock_i), .reset_n_i(rst_lo),
		.boots_o(boots));
	initial forever #25 clock_i = ~clock_i;
	task automatic chk(string s, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	// Sample at the falling edge, return on the rising edge
	task automatic step(int k);
		repeat (k) begin
			@(negedge clock_i);
			act_s = !rst_lo;
			chk("polarity", {7'h0, !rst_lo}, {7'h0, rst_hi});
			@(posedge clock_i);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wait_rel();
		n = 0;
		while (act_s !== 1'h0 && n < 300) begin
			step(1);
			n++;
		end
		if (n >= 300) begin
			n_mismatch++;
			give_verdict();
		end
		chk("hold", 8'h1, {7'h0, n >= HC - 4 && n <= HC + 12});
	endtask
	task automatic t_brown();
		low <= 1'h1;
		step(12);
		chk("brownout", 8'h1, {7'h0, act_s});
		low <= 1'h0;
		step(20);
		low <= 1'h1;
		step(8);
		low <= 1'h0;
		wait_rel();
	endtask
	task automatic t_manual();
		low <= 1'h1;
		step(2);
		b = boots;
		low <= 1'h0;
		repeat (3) begin
			mr_n <= 1'h0;
			step(2);
			mr_n <= 1'h1;
			step(2);
		end
		step(10);
		chk("glitch", 8'h0, {7'h0, act_s});
		mr_n <= 1'h0;
		step(20);
		chk("delay", 8'h0, {7'h0, act_s});
		step(180);
		chk("manual", 8'h1, {7'h0, act_s});
		mr_n <= 1'h1;
		wait_rel();
		step(2);
		chk("starts", b + 8'h1, boots);
	endtask
	initial begin
		step(16);
		rst_i <= 1'h0;
		step(1);
		wait_rel();
		t_brown();
		t_manual();
		give_verdict();
	end
endmodule // supply_reset_supervisor_tb
bind supply_reset_supervisor supervisor_properties #(
	.ACTIVE_HIGH(ACTIVE_HIGH), .HOLD_CYC(HOLD_CYC)) chk_i (
	.clock_i(clock_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
	.manual_reset_n_i(manual_reset_n_i), .reset_o(reset_o));
